/* File: rtl/pvl_limits.sv */
`timescale 1ns/10ps
`include "pvl_consts.svh"
// Functional notes
// - Turn-on threshold word, conversion starts at it
// - Turn-off threshold word, conversion stops at it
// - Input overvoltage limit raises input fault
// - Undervoltage warning armed after turn-on and enable
// - Undervoltage warning sets status bits and alert
// - Format command returns fixed byte 0x14
// - Writing format command flags CML fault
// - Paged setpoint word, reset 0x1000
// - Setpoint waits for ramps, then slews
// - Absolute maximum bounds output commands except load-line
// - Ceiling caps every voltage-setting command
// - Ceiling above absolute maximum: CML, loaded max
// - Ceiling warning above range-dependent level
// - Clamp to ceiling, set warning and alert
// - Paged load-line percentage register
// - Nonzero load-line mantissa forces servo off
// - Margin high selects high-margin level
// - Margin low selects low-margin level
// - Common status bits 6:5 low while settling
// - Output overvoltage warning sets bits and alert
module pvl_limits
	import pvl_pkg::*;
#(
	parameter logic [6:0] BUS_ADDRESS    = 7'h40,
	parameter int         OV_SETTLE_CYCLES = `PVL_OV_SETTLE_CYC
) (
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe,
	output logic                        alert_out,
	output logic                        alert_oe,
	input  wire logic                   unit_enable,
	input  wire logic [15:0]            vin_meas,
	input  wire logic [1:0][15:0]       vout_meas,
	input  wire pvl_margin_e            margin_sel [2],
	input  wire logic [1:0]             range_sel,
	input  wire logic [1:0]             servo_req,
	input  wire logic [1:0]             ramp_busy,
	input  wire logic [1:0]             chan_on,
	input  wire pvl_mask_s              alert_mask,
	input  wire logic                   clear_status,
	output logic                        conversion_en,
	output logic [1:0][15:0]            vout_target,
	output logic [1:0]                  servo_en,
	output logic [7:0]                  common_status,
	output pvl_status_s                 status
);

	// Pin sampling: [0] and [1] synchronise, [2] holds the previous level
	logic [2:0]  scl_s;
	logic [2:0]  sda_s;
	pvl_bus_e    bus_st;
	logic [3:0]  bitc;
	logic [7:0]  sh;
	logic [7:0]  tx;
	logic        ack_ph;
	logic        rd_req;
	logic        mnack;
	logic        byte_n;
	logic [7:0]  cmd;
	logic [7:0]  lo;
	pvl_commit_s cmt;

	logic [15:0] pg [2][9];
	logic [15:0] np [4];
	logic [7:0]  page;
	logic        armed;
	logic [17:0] settle_cnt;
	logic [4:0]  slew_div;

	wire scl_rise = scl_s[1] & ~scl_s[2];
	wire scl_fall = ~scl_s[1] & scl_s[2];
	wire bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	wire bus_stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
	wire byte_cmd  = (cmd == `PVL_CMD_PAGE) || (cmd == `PVL_CMD_FORMAT);
	wire slew_tick = (slew_div == 5'd0);

	function automatic logic [4:0] pidx(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h0f;
		if (c == `PVL_CMD_SETPOINT) r = {1'b1, `PVL_PI_SETPOINT};
		else if (c == `PVL_CMD_CEILING) r = {1'b1, `PVL_PI_CEILING};
		else if (c == `PVL_CMD_MARGIN_HI) r = {1'b1, `PVL_PI_MARGIN_HI};
		else if (c == `PVL_CMD_MARGIN_LO) r = {1'b1, `PVL_PI_MARGIN_LO};
		else if (c == `PVL_CMD_VOUT_OVF) r = {1'b1, `PVL_PI_VOUT_OVF};
		else if (c == `PVL_CMD_VOUT_OVW) r = {1'b1, `PVL_PI_VOUT_OVW};
		else if (c == `PVL_CMD_VOUT_UVW) r = {1'b1, `PVL_PI_VOUT_UVW};
		else if (c == `PVL_CMD_VOUT_UVF) r = {1'b1, `PVL_PI_VOUT_UVF};
		else if (c == `PVL_CMD_LOAD_LINE) r = {1'b1, `PVL_PI_LOAD_LINE};
		return r;
	endfunction

	function automatic logic [2:0] nidx(input logic [7:0] c);
		logic [2:0] r;
		r = 3'h0;
		if (c == `PVL_CMD_INPUT_TURN_ON_THRESHOLD) r = {1'b1, `PVL_NI_INPUT_TURN_ON_THRESHOLD};
		else if (c == `PVL_CMD_INPUT_TURN_OFF_THRESHOLD) r = {1'b1, `PVL_NI_INPUT_TURN_OFF_THRESHOLD};
		else if (c == `PVL_CMD_VIN_OVF) r = {1'b1, `PVL_NI_VIN_OVF};
		else if (c == `PVL_CMD_VIN_UVW) r = {1'b1, `PVL_NI_VIN_UVW};
		return r;
	endfunction

	function automatic logic [15:0] pg_rst(input int i);
		logic [15:0] r;
		r = `PVL_RST_LOAD_LINE;
		case (i)
			0: r = `PVL_RST_SETPOINT;
			1: r = `PVL_RST_CEILING;
			2: r = `PVL_RST_MARGIN_HI;
			3: r = `PVL_RST_MARGIN_LO;
			4: r = `PVL_RST_VOUT_OVF;
			5: r = `PVL_RST_VOUT_OVW;
			6: r = `PVL_RST_VOUT_UVW;
			7: r = `PVL_RST_VOUT_UVF;
			default: r = `PVL_RST_LOAD_LINE;
		endcase
		return r;
	endfunction

	// Read selection
	wire        ch       = page[0];
	wire [4:0]  r_pi     = pidx(cmd);
	wire [2:0]  r_ni     = nidx(cmd);
	logic [15:0] rd_word;
	always_comb begin
		rd_word = 16'h0000;
		if (cmd == `PVL_CMD_FORMAT) rd_word = {8'h00, `PVL_FORMAT_VAL};
		else if (cmd == `PVL_CMD_PAGE) rd_word = {8'h00, page};
		else if (cmd == `PVL_CMD_ABS_MAX) rd_word = `PVL_ABS_MAX_VAL;
		else if (r_pi[4]) rd_word = pg[ch][r_pi[3:0]];
		else if (r_ni[2]) rd_word = np[r_ni[1:0]];
	end

	// Serial port
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else begin
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bus_st <= BUS_IDLE;
			bitc   <= 4'h0;
			sh     <= 8'h00;
			tx     <= 8'h00;
			ack_ph <= 1'b0;
			rd_req <= 1'b0;
			mnack  <= 1'b0;
			byte_n <= 1'b0;
			cmd    <= 8'h00;
			lo     <= 8'h00;
			sda_oe <= 1'b0;
			cmt    <= '0;
		end else begin
			cmt.valid <= 1'b0;
			if (bus_start) begin
				bus_st <= BUS_ADDR;
				bitc   <= 4'h0;
				ack_ph <= 1'b0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				bus_st <= BUS_IDLE;
				ack_ph <= 1'b0;
				sda_oe <= 1'b0;
			end else if (bus_st != BUS_IDLE) begin
				if (scl_rise && !ack_ph) begin
					sh   <= {sh[6:0], sda_s[1]};
					bitc <= bitc + 4'h1;
				end else if (scl_rise && bus_st == BUS_RDATA) begin
					mnack <= sda_s[1];
				end
				if (scl_fall && !ack_ph && bitc == 4'h8) begin
					ack_ph <= 1'b1;
					bitc   <= 4'h0;
					sda_oe <= 1'b1;
					case (bus_st)
						BUS_ADDR: begin
							rd_req <= sh[0];
							if (sh[7:1] != BUS_ADDRESS) begin
								bus_st <= BUS_IDLE;
								sda_oe <= 1'b0;
							end
						end
						BUS_CMD: begin
							cmd    <= sh;
							byte_n <= 1'b0;
						end
						BUS_WDATA: begin
							byte_n <= 1'b1;
							lo     <= sh;
							if (byte_cmd || byte_n) begin
								cmt.valid <= 1'b1;
								cmt.cmd   <= cmd;
								cmt.data  <= byte_cmd ? {8'h00, sh} : {sh, lo};
							end
						end
						default: sda_oe <= 1'b0;
					endcase
				end else if (scl_fall && ack_ph) begin
					ack_ph <= 1'b0;
					sda_oe <= 1'b0;
					case (bus_st)
						BUS_ADDR: begin
							if (rd_req) begin
								bus_st <= BUS_RDATA;
								tx     <= rd_word[7:0];
								sda_oe <= ~rd_word[7];
								byte_n <= 1'b0;
							end else begin
								bus_st <= BUS_CMD;
							end
						end
						BUS_CMD: bus_st <= BUS_WDATA;
						BUS_RDATA: begin
							if (mnack) begin
								bus_st <= BUS_IDLE;
							end else begin
								tx     <= rd_word[15:8];
								sda_oe <= ~rd_word[15];
								byte_n <= 1'b1;
							end
						end
						default: bus_st <= bus_st;
					endcase
				end else if (scl_fall && bus_st == BUS_RDATA && !ack_ph) begin
					tx     <= {tx[6:0], 1'b0};
					sda_oe <= ~tx[6];
				end
			end
		end
	end

	// Write path with clamping
	wire [4:0]  w_pi   = pidx(cmt.cmd);
	wire [2:0]  w_ni   = nidx(cmt.cmd);
	wire [15:0] w_ceil = pg[ch][`PVL_PI_CEILING];
	wire        w_set  = w_pi[3:0] == `PVL_PI_SETPOINT || w_pi[3:0] == `PVL_PI_MARGIN_HI ||
	                     w_pi[3:0] == `PVL_PI_MARGIN_LO;
	wire        w_ro   = cmt.valid && (cmt.cmd == `PVL_CMD_FORMAT || cmt.cmd == `PVL_CMD_ABS_MAX ||
	                     (!w_pi[4] && !w_ni[2] && cmt.cmd != `PVL_CMD_PAGE));
	wire        w_ceil_over = cmt.valid && w_pi[4] && w_pi[3:0] == `PVL_PI_CEILING &&
	                          cmt.data > `PVL_ABS_MAX_VAL;
	wire        w_set_over  = cmt.valid && w_pi[4] && w_set && cmt.data > w_ceil;
	logic [15:0] w_val;
	always_comb begin
		w_val = cmt.data;
		if (w_ceil_over) w_val = `PVL_ABS_MAX_VAL;
		else if (w_set_over) w_val = (w_ceil > `PVL_ABS_MAX_VAL) ? `PVL_ABS_MAX_VAL : w_ceil;
		else if (w_pi[3:0] != `PVL_PI_LOAD_LINE && cmt.data > `PVL_ABS_MAX_VAL) w_val = `PVL_ABS_MAX_VAL;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			page <= 8'h00;
			for (int c = 0; c < 2; c++) begin
				for (int i = 0; i < 9; i++) begin
					pg[c][i] <= pg_rst(i);
				end
			end
			np[0] <= `PVL_RST_INPUT_TURN_ON_THRESHOLD;
			np[1] <= `PVL_RST_INPUT_TURN_OFF_THRESHOLD;
			np[2] <= `PVL_RST_VIN_OVF;
			np[3] <= `PVL_RST_VIN_UVW;
		end else if (cmt.valid) begin
			if (cmt.cmd == `PVL_CMD_PAGE) page <= cmt.data[7:0];
			else if (w_pi[4]) pg[ch][w_pi[3:0]] <= w_val;
			else if (w_ni[2]) np[w_ni[1:0]] <= cmt.data;
		end
	end

	// Per-channel target, clamp and warnings
	logic [1:0][15:0] sel;
	logic [1:0][15:0] tgt;
	logic [1:0]       clamp_hit;
	logic [1:0]       ceil_warn;
	logic [1:0]       ov_warn;
	logic [1:0]       load_line_on;
	for (genvar c = 0; c < 2; c++) begin : g_ch
		assign sel[c] = (margin_sel[c] == MARGIN_HIGH) ? pg[c][`PVL_PI_MARGIN_HI] :
		                (margin_sel[c] == MARGIN_LOW)  ? pg[c][`PVL_PI_MARGIN_LO] :
		                pg[c][`PVL_PI_SETPOINT];
		assign clamp_hit[c] = sel[c] > pg[c][`PVL_PI_CEILING];
		assign tgt[c] = clamp_hit[c] ? pg[c][`PVL_PI_CEILING] : sel[c];
		assign ceil_warn[c] = pg[c][`PVL_PI_CEILING] > (range_sel[c] ? `PVL_CEIL_WARN_R1 : `PVL_CEIL_WARN_R0);
		assign ov_warn[c] = vout_meas[c] > pg[c][`PVL_PI_VOUT_OVW];
		assign load_line_on[c] = pg[c][`PVL_PI_LOAD_LINE][`PVL_L11_MANT_MSB:0] != 11'h000;
	end

	wire signed [10:0] vin_m  = vin_meas[`PVL_L11_MANT_MSB:0];
	wire signed [10:0] on_m   = np[`PVL_NI_INPUT_TURN_ON_THRESHOLD][`PVL_L11_MANT_MSB:0];
	wire signed [10:0] off_m  = np[`PVL_NI_INPUT_TURN_OFF_THRESHOLD][`PVL_L11_MANT_MSB:0];
	wire signed [10:0] ovf_m  = np[`PVL_NI_VIN_OVF][`PVL_L11_MANT_MSB:0];
	wire signed [10:0] uvw_m  = np[`PVL_NI_VIN_UVW][`PVL_L11_MANT_MSB:0];
	wire               uv_hit = armed && vin_m < uvw_m;
	wire               set_uv = uv_hit;

	pvl_status_s set_s;
	always_comb begin
		set_s               = '0;
		set_s.cml_fault     = w_ro | w_ceil_over;
		set_s.vin_ov_fault  = vin_m > ovf_m;
		set_s.vin_uv_warn   = set_uv;
		set_s.input_summary = set_uv;
		set_s.vout_ov_warn  = ov_warn;
		set_s.output_ceiling_warn = clamp_hit | ceil_warn | ({2{w_set_over}} & {ch, ~ch});
		set_s.vout_summary  = ov_warn | clamp_hit | ceil_warn | ({2{w_set_over}} & {ch, ~ch});
	end

	wire alert_any = (status.cml_fault && !alert_mask.cml) || (status.vin_uv_warn && !alert_mask.vin_uv) ||
	                 ((|status.vout_ov_warn) && !alert_mask.vout_ov) ||
	                 ((|status.output_ceiling_warn) && !alert_mask.output_ceiling);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status        <= '0;
			alert_oe      <= 1'b0;
			alert_out     <= 1'b0;
			sda_out       <= 1'b0;
			conversion_en <= 1'b0;
			armed         <= 1'b0;
			settle_cnt    <= 18'h0;
			common_status <= 8'h00;
			servo_en      <= 2'b00;
		end else begin
			// New events win over a clear in the same cycle
			status   <= clear_status ? set_s : (status | set_s);
			alert_oe <= alert_any;
			if (vin_m >= on_m) conversion_en <= 1'b1;
			else if (vin_m <= off_m) conversion_en <= 1'b0;
			if (!unit_enable) armed <= 1'b0;
			else if (vin_m > on_m) armed <= 1'b1;
			if (cmt.valid && w_pi[4] && w_pi[3:0] == `PVL_PI_VOUT_OVF && chan_on[ch]) begin
				settle_cnt <= 18'(OV_SETTLE_CYCLES);
			end else if (settle_cnt != 18'h0) begin
				settle_cnt <= settle_cnt - 18'h1;
			end
			common_status <= 8'h00;
			common_status[`PVL_CSTAT_SETTLE_HI] <= (settle_cnt == 18'h0);
			common_status[`PVL_CSTAT_SETTLE_LO] <= (settle_cnt == 18'h0);
			servo_en <= servo_req & ~load_line_on;
		end
	end

	// Output slewing at the transition rate, held while a ramp runs
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			slew_div    <= 5'h0;
			vout_target <= {`PVL_RST_SETPOINT, `PVL_RST_SETPOINT};
		end else begin
			slew_div <= slew_tick ? 5'(`PVL_SLEW_CYC - 1) : slew_div - 5'h1;
			for (int c = 0; c < 2; c++) begin
				if (!ramp_busy[c] && slew_tick) begin
					if (vout_target[c] < tgt[c]) vout_target[c] <= vout_target[c] + 16'h1;
					else if (vout_target[c] > tgt[c]) vout_target[c] <= vout_target[c] - 16'h1;
				end
			end
		end
	end

	property p_fmt;
		@(posedge clock) disable iff (!resetn) (cmd == `PVL_CMD_FORMAT) |-> rd_word == 16'h0014;
	endproperty
	a_fmt: assert property (p_fmt) else $error("format byte wrong");

	property p_fmt_wr;
		@(posedge clock) disable iff (!resetn)
			(cmt.valid && cmt.cmd == `PVL_CMD_FORMAT) |=> status.cml_fault;
	endproperty
	a_fmt_wr: assert property (p_fmt_wr) else $error("format write not flagged");

	property p_ceil_abs;
		@(posedge clock) disable iff (!resetn) pg[0][`PVL_PI_CEILING] <= 16'h599a;
	endproperty
	a_ceil_abs: assert property (p_ceil_abs) else $error("ceiling above absolute maximum");

	property p_tgt_cap;
		@(posedge clock) disable iff (!resetn)
			clamp_hit[0] |-> (tgt[0] == pg[0][`PVL_PI_CEILING]) ##1 status.output_ceiling_warn[0];
	endproperty
	a_tgt_cap: assert property (p_tgt_cap) else $error("target not capped");

	property p_load_line_servo;
		@(posedge clock) disable iff (!resetn) load_line_on[0] |=> !servo_en[0];
	endproperty
	a_load_line_servo: assert property (p_load_line_servo) else $error("servo left on with load line");

	property p_uv_warn;
		@(posedge clock) disable iff (!resetn)
			(armed && vin_m < uvw_m) |=> (status.vin_uv_warn && status.input_summary);
	endproperty
	a_uv_warn: assert property (p_uv_warn) else $error("input warning not raised");

	property p_ov_settle;
		@(posedge clock) disable iff (!resetn)
			(cmt.valid && cmt.cmd == `PVL_CMD_VOUT_OVF && chan_on[ch]) |=> ##1 (common_status[6:5] == 2'b00)[*4];
	endproperty
	a_ov_settle: assert property (p_ov_settle) else $error("settle bits not low");

	property p_defer;
		@(posedge clock) disable iff (!resetn) ramp_busy[0] |=> $stable(vout_target[0]);
	endproperty
	a_defer: assert property (p_defer) else $error("target moved during ramp");

	property p_conv_off;
		@(posedge clock) disable iff (!resetn) (vin_m <= off_m && vin_m < on_m) |=> !conversion_en;
	endproperty
	a_conv_off: assert property (p_conv_off) else $error("conversion not stopped");

endmodule

/* File: rtl/pvl_consts.svh */
`ifndef PVL_CONSTS_SVH
`define PVL_CONSTS_SVH

// Command codes
`define PVL_CMD_PAGE      8'h00
`define PVL_CMD_FORMAT    8'h20
`define PVL_CMD_SETPOINT  8'h21
`define PVL_CMD_CEILING   8'h24
`define PVL_CMD_MARGIN_HI 8'h25
`define PVL_CMD_MARGIN_LO 8'h26
`define PVL_CMD_INPUT_TURN_ON_THRESHOLD    8'h35
`define PVL_CMD_INPUT_TURN_OFF_THRESHOLD   8'h36
`define PVL_CMD_VOUT_OVF  8'h40
`define PVL_CMD_VOUT_OVW  8'h42
`define PVL_CMD_VOUT_UVW  8'h43
`define PVL_CMD_VOUT_UVF  8'h44
`define PVL_CMD_VIN_OVF   8'h55
`define PVL_CMD_VIN_UVW   8'h58
`define PVL_CMD_ABS_MAX   8'ha5
`define PVL_CMD_LOAD_LINE 8'hd3

// Reset and fixed values
`define PVL_FORMAT_VAL    8'h14
`define PVL_RST_SETPOINT  16'h1000
`define PVL_RST_CEILING   16'h5800
`define PVL_RST_MARGIN_HI 16'h10cd
`define PVL_RST_MARGIN_LO 16'h0f33
`define PVL_RST_VOUT_OVF  16'h119a
`define PVL_RST_VOUT_OVW  16'h1133
`define PVL_RST_VOUT_UVW  16'h0ecd
`define PVL_RST_VOUT_UVF  16'h0e66
`define PVL_RST_LOAD_LINE 16'h8000
`define PVL_RST_INPUT_TURN_ON_THRESHOLD    16'hcb40
`define PVL_RST_INPUT_TURN_OFF_THRESHOLD   16'hcb00
`define PVL_RST_VIN_OVF   16'hd3e0
`define PVL_RST_VIN_UVW   16'hcb26
`define PVL_ABS_MAX_VAL   16'h599a
`define PVL_CEIL_WARN_R0  16'h5800
`define PVL_CEIL_WARN_R1  16'h2c00

// Slot indices in the per-page store (PI) and in the unpaged store (NI)
`define PVL_PI_SETPOINT  4'd0
`define PVL_PI_CEILING   4'd1
`define PVL_PI_MARGIN_HI 4'd2
`define PVL_PI_MARGIN_LO 4'd3
`define PVL_PI_VOUT_OVF  4'd4
`define PVL_PI_VOUT_OVW  4'd5
`define PVL_PI_VOUT_UVW  4'd6
`define PVL_PI_VOUT_UVF  4'd7
`define PVL_PI_LOAD_LINE 4'd8
`define PVL_NI_INPUT_TURN_ON_THRESHOLD    2'd0
`define PVL_NI_INPUT_TURN_OFF_THRESHOLD   2'd1
`define PVL_NI_VIN_OVF   2'd2
`define PVL_NI_VIN_UVW   2'd3

// Field positions
`define PVL_L11_MANT_MSB 10
`define PVL_CSTAT_SETTLE_HI 6
`define PVL_CSTAT_SETTLE_LO 5

// Timing
`define PVL_CLK_KHZ        25000
`define PVL_OV_SETTLE_MS   10
`define PVL_OV_SETTLE_CYC  (`PVL_OV_SETTLE_MS * `PVL_CLK_KHZ)
`define PVL_SLEW_LSB_PER_MS 1024
`define PVL_SLEW_CYC       (`PVL_CLK_KHZ / `PVL_SLEW_LSB_PER_MS)

`endif

/* File: rtl/pvl_pkg.sv */
package pvl_pkg;

	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_CMD,
		BUS_WDATA,
		BUS_RDATA
	} pvl_bus_e;

	typedef enum logic [1:0] {
		MARGIN_NONE,
		MARGIN_LOW,
		MARGIN_HIGH
	} pvl_margin_e;

	typedef struct packed {
		logic        valid;
		logic [7:0]  cmd;
		logic [15:0] data;
	} pvl_commit_s;

	typedef struct packed {
		logic       cml_fault;
		logic       vin_ov_fault;
		logic       input_summary;
		logic       vin_uv_warn;
		logic [1:0] vout_summary;
		logic [1:0] vout_ov_warn;
		logic [1:0] output_ceiling_warn;
	} pvl_status_s;

	typedef struct packed {
		logic cml;
		logic output_ceiling;
		logic vout_ov;
		logic vin_uv;
	} pvl_mask_s;

endpackage

/* File: dv/pvl_host.sv */
`timescale 1ns/10ps
module pvl_host #(
	parameter logic [6:0] ADDR = 7'h40
) (
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda_line
);
	// Serial clock idles high and toggles only inside a frame; a released data line floats to its pull-up
	logic [6:0] dev_addr = ADDR;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Data changes in the low phase and is sampled in the middle of the high phase
	task automatic bit9(input logic b, output logic got);
		#40 sda_pull = !b;
		#120 scl = 1'b1;
		#80 got = sda_line;
		#80 scl = 1'b0;
	endtask

	task automatic start_c();
		#40 sda_pull = 1'b0;
		#120 scl = 1'b1;
		#160 sda_pull = 1'b1;
		#160 scl = 1'b0;
	endtask

	task automatic stop_c();
		#40 sda_pull = 1'b1;
		#120 scl = 1'b1;
		#160 sda_pull = 1'b0;
		#160;
	endtask

	task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic nak);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit9(d[i], g);
			q = {q[6:0], g};
		end
		bit9(ack_in, nak);
	endtask

	// Odd phase offset keeps pin changes away from the core clock edges
	task automatic head(input logic [7:0] cmd, output logic nak);
		logic [7:0] q;
		logic       n0;
		logic       n1;
		#7;
		start_c();
		xbyte({dev_addr, 1'b0}, 1'b1, q, n0);
		xbyte(cmd, 1'b1, q, n1);
		nak = n0 | n1;
	endtask

	task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic nak);
		logic [7:0] q;
		logic       n0;
		logic       n1;
		logic       n2;
		head(cmd, n0);
		xbyte(d[7:0], 1'b1, q, n1);
		xbyte(d[15:8], 1'b1, q, n2);
		stop_c();
		nak = n0 | n1 | n2;
	endtask

	task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic       n0;
		logic       n1;
		head(cmd, n0);
		xbyte(d, 1'b1, q, n1);
		stop_c();
		nak = n0 | n1;
	endtask

	// Word reads acknowledge the low byte and refuse the high byte; byte reads refuse the only byte
	task automatic rd(input logic [7:0] cmd, input logic word, output logic [15:0] d);
		logic [7:0] lo;
		logic [7:0] hi;
		logic       n;
		head(cmd, n);
		start_c();
		xbyte({dev_addr, 1'b1}, 1'b1, lo, n);
		xbyte(8'hff, !word, lo, n);
		hi = 8'h00;
		if (word) begin
			xbyte(8'hff, 1'b1, hi, n);
		end
		stop_c();
		d = {hi, lo};
	endtask
endmodule

/* File: dv/tb_pvl_limits.sv */
`timescale 1ns/10ps
module tb_pvl_limits
	import pvl_pkg::*;
();
	typedef struct packed {
		logic [7:0]  cmd;
		logic [15:0] rst;
		logic [15:0] wr;
		logic [15:0] exp;
	} pvl_row_s;

	logic             clock        = 1'b0;
	logic             resetn       = 1'b0;
	logic             unit_enable  = 1'b0;
	logic [15:0]      vin_meas     = 16'hca00;
	logic [1:0][15:0] vout_meas    = {16'h1000, 16'h1000};
	pvl_margin_e      margin_sel [2] = '{MARGIN_NONE, MARGIN_NONE};
	logic [1:0]       range_sel    = 2'b00;
	logic [1:0]       servo_req    = 2'b11;
	logic [1:0]       ramp_busy    = 2'b01;
	logic [1:0]       chan_on      = 2'b00;
	pvl_mask_s        alert_mask   = '0;
	logic             clear_status = 1'b0;
	logic             scl;
	logic             sda_pull;
	logic             sda_out;
	logic             sda_oe;
	logic             alert_out;
	logic             alert_oe;
	logic             conversion_en;
	logic [1:0][15:0] vout_target;
	logic [1:0]       servo_en;
	logic [7:0]       common_status;
	pvl_status_s      status;
	wire logic        sda_line;
	int               n_fail       = 0;
	int               checked      = 0;
	pvl_row_s         rows [14]    = '{
		'{8'h21, 16'h1000, 16'h1234, 16'h1234},
		'{8'h24, 16'h5800, 16'h5000, 16'h5000},
		'{8'h25, 16'h10cd, 16'h1300, 16'h1300},
		'{8'h26, 16'h0f33, 16'h0e00, 16'h0e00},
		'{8'h35, 16'hcb40, 16'hcb50, 16'hcb50},
		'{8'h36, 16'hcb00, 16'hcb10, 16'hcb10},
		'{8'h40, 16'h119a, 16'h1200, 16'h1200},
		'{8'h42, 16'h1133, 16'h1180, 16'h1180},
		'{8'h43, 16'h0ecd, 16'h0e80, 16'h0e80},
		'{8'h44, 16'h0e66, 16'h0e10, 16'h0e10},
		'{8'h55, 16'hd3e0, 16'hd3f0, 16'hd3f0},
		'{8'h58, 16'hcb26, 16'hcb30, 16'hcb30},
		'{8'ha5, 16'h599a, 16'h0100, 16'h599a},
		'{8'hd3, 16'h8000, 16'h8010, 16'h8010}
	};

	// Open-drain data line: low when either party pulls, pull-up otherwise
	assign sda_line = (sda_oe ? sda_out : 1'b1) & !sda_pull;

	always #20 clock = !clock;

	pvl_limits #(.BUS_ADDRESS(7'h40), .OV_SETTLE_CYCLES(20)) dut_u (
		.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .unit_enable(unit_enable),
		.vin_meas(vin_meas), .vout_meas(vout_meas), .margin_sel(margin_sel), .range_sel(range_sel),
		.servo_req(servo_req), .ramp_busy(ramp_busy), .chan_on(chan_on), .alert_mask(alert_mask),
		.clear_status(clear_status), .conversion_en(conversion_en), .vout_target(vout_target),
		.servo_en(servo_en), .common_status(common_status), .status(status)
	);

	pvl_host #(.ADDR(7'h40)) host_u (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic bad(input logic [15:0] got, input logic [15:0] exp);
		n_fail++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad(got, exp);
		end
	endtask

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	task automatic clr();
		cyc(1);
		clear_status <= 1'b1;
		cyc(1);
		clear_status <= 1'b0;
		cyc(3);
	endtask

	// Channel 0 target must move about four steps in the given direction
	task automatic slew(input logic up);
		logic [15:0] a;
		logic [15:0] d;
		a = vout_target[0];
		cyc(99);
		d = up ? vout_target[0] - a : a - vout_target[0];
		checked++;
		if ((d >= 16'h3 && d <= 16'h5) !== 1'b1) begin
			bad(d, 16'h4);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#3_000_000;
		n_fail++;
		$display("BAD t=%0t watchdog", $time);
		test_done();
	end

	initial begin
		logic [15:0] d;
		logic        nak;
		cyc(5);
		resetn <= 1'b1;
		cyc(3);
		chk(16'(common_status), 16'h0060);
		chk(16'(servo_en), 16'h0003);
		chk(vout_target[1], 16'h1000);
		chk(16'(status), 16'h0000);
		chk(16'(conversion_en), 16'h0000);
		chk(16'({alert_out, sda_out}), 16'h0000);
		tdone("reset");
		unit_enable <= 1'b1;
		vin_meas <= 16'hcb50;
		cyc(4);
		chk(16'(conversion_en), 16'h0001);
		vin_meas <= 16'hcb20;
		cyc(4);
		chk(16'(conversion_en), 16'h0001);
		chk(16'({status.input_summary, status.vin_uv_warn, alert_oe}), 16'h0007);
		vin_meas <= 16'hcaf0;
		cyc(4);
		chk(16'(conversion_en), 16'h0000);
		vin_meas <= 16'hcbf0;
		cyc(4);
		chk(16'(status.vin_ov_fault), 16'h0001);
		vin_meas <= 16'hcb50;
		clr();
		chk(16'(status), 16'h0000);
		tdone("input");
		alert_mask <= '{cml: 1'b1, default: 1'b0};
		host_u.wr_byte(8'h20, 8'h55, nak);
		cyc(4);
		chk(16'({nak, status.cml_fault, alert_oe}), 16'h0002);
		alert_mask <= '0;
		cyc(3);
		chk(16'(alert_oe), 16'h0001);
		host_u.rd(8'h20, 1'b0, d);
		chk(d, 16'h0014);
		clr();
		tdone("format");
		foreach (rows[i]) begin
			cyc(1);
			host_u.rd(rows[i].cmd, 1'b1, d);
			chk(d, rows[i].rst);
			host_u.wr_word(rows[i].cmd, rows[i].wr, nak);
			host_u.rd(rows[i].cmd, 1'b1, d);
			chk(d, rows[i].exp);
		end
		cyc(4);
		chk(16'(servo_en), 16'h0002);
		chk(16'(status.cml_fault), 16'h0001);
		clr();
		tdone("table");
		host_u.wr_word(8'h24, 16'h6000, nak);
		host_u.rd(8'h24, 1'b1, d);
		chk(d, 16'h599a);
		chk(16'(status.cml_fault), 16'h0001);
		host_u.wr_word(8'h24, 16'h5000, nak);
		clr();
		host_u.wr_word(8'h21, 16'h5800, nak);
		host_u.rd(8'h21, 1'b1, d);
		chk(d, 16'h5000);
		chk(16'({status.vout_summary[0], status.output_ceiling_warn[0], alert_oe}), 16'h0007);
		tdone("ceiling");
		host_u.wr_byte(8'h00, 8'h01, nak);
		host_u.wr_word(8'h21, 16'h0800, nak);
		host_u.rd(8'h21, 1'b1, d);
		chk(d, 16'h0800);
		host_u.rd(8'h24, 1'b1, d);
		chk(d, 16'h5800);
		host_u.rd(8'h35, 1'b1, d);
		chk(d, 16'hcb50);
		host_u.wr_byte(8'h00, 8'h00, nak);
		host_u.dev_addr = 7'h41;
		host_u.wr_word(8'h21, 16'h0123, nak);
		chk(16'(nak), 16'h0001);
		host_u.dev_addr = 7'h40;
		host_u.rd(8'h21, 1'b1, d);
		chk(d, 16'h5000);
		tdone("paging");
		clr();
		range_sel <= 2'b10;
		vout_meas[1] <= 16'h1200;
		cyc(4);
		chk(16'({status.output_ceiling_warn[1], status.vout_ov_warn[1], status.vout_summary[1]}), 16'h0007);
		tdone("warnings");
		chan_on <= 2'b01;
		host_u.wr_word(8'h40, 16'h1100, nak);
		chk(16'(common_status[6:5]), 16'h0000);
		cyc(30);
		chk(16'(common_status[6:5]), 16'h0003);
		tdone("settle");
		margin_sel[0] <= MARGIN_LOW;
		cyc(100);
		chk(vout_target[0], 16'h1000);
		ramp_busy <= 2'b00;
		slew(1'b0);
		margin_sel[0] <= MARGIN_HIGH;
		slew(1'b1);
		host_u.wr_word(8'h24, 16'h1100, nak);
		cyc(4);
		chk(16'({status.output_ceiling_warn[0], status.vout_summary[0]}), 16'h0003);
		tdone("slew");
		test_done();
	end
endmodule
